// >>> rtl/ocm_pkg.sv
// Package for the offcore miss event matcher and the retirement event counter.
// Assumes a single core clock and that all pipeline inputs are on that clock.
package ocm_pkg;

    // Register address and layout of the matrix select register
    localparam logic [11:0] OCM_MATCH_SELECT_ADDR = 12'h1A6;
    localparam int OCM_SEL_W = 16;
    localparam int OCM_REQ_LSB = 0;
    localparam int OCM_RSP_LSB = 8;
    localparam int OCM_GRP_W = 8;
    localparam logic [15:0] OCM_SEL_RESET = 16'h0000;

    // Request-type bit positions in the low byte
    localparam int OCM_REQ_DMD_DATA_RD = 0;
    localparam int OCM_REQ_DMD_READ_FOR_OWNERSHIP = 1;
    localparam int OCM_REQ_DMD_IFETCH = 2;
    localparam int OCM_REQ_WRITEBACK = 3;
    localparam int OCM_REQ_PF_DATA_RD = 4;
    localparam int OCM_REQ_PF_READ_FOR_OWNERSHIP = 5;
    localparam int OCM_REQ_PF_IFETCH = 6;
    localparam int OCM_REQ_OTHER = 7;

    // Event codes of the retirement and offcore events; unit masks of the retirement events
    localparam logic [7:0] OCM_EV_INST_DONE = 8'hC0;
    localparam logic [7:0] OCM_EV_UOPS_DONE = 8'hC2;
    localparam logic [7:0] OCM_EV_X87_ASSIST = 8'hF7;
    localparam logic [7:0] OCM_EV_OFFCORE = 8'hB7;
    localparam logic [7:0] OCM_UM_INST_ANY = 8'h01;
    localparam logic [7:0] OCM_UM_UOPS_ANY = 8'h01;
    localparam logic [7:0] OCM_UM_ASSIST_ANY = 8'h01;
    localparam logic [7:0] OCM_UM_ASSIST_OUT = 8'h02;
    localparam logic [7:0] OCM_UM_ASSIST_IN = 8'h04;

    localparam int OCM_CTR_W = 48;
    localparam logic [47:0] OCM_CTR_RESET = 48'h0000_0000_0000;
    localparam int OCM_IP_W = 48;

    // Kind of access that caused a second-level miss
    typedef enum logic [2:0] {
        OCM_KIND_DATA_RD,
        OCM_KIND_READ_FOR_OWNERSHIP,
        OCM_KIND_IFETCH,
        OCM_KIND_WRITEBACK,
        OCM_KIND_NT_STORE,
        OCM_KIND_MISC
    } ocm_kind_e;

    // Who issued the request
    typedef enum logic [1:0] {
        OCM_SRC_CORE,
        OCM_SRC_L1D_PF,
        OCM_SRC_L2_PF
    } ocm_src_e;

    // Where the miss was served; order matches response bits 8..15
    typedef enum logic [2:0] {
        OCM_RSP_L3_UNSHARED,
        OCM_RSP_L3_SHARED_CLEAN,
        OCM_RSP_L3_HIT_MOD_OTHER,
        OCM_RSP_REMOTE_SCRUB,
        OCM_RSP_REMOTE_FWD,
        OCM_RSP_REMOTE_MEM,
        OCM_RSP_LOCAL_MEM,
        OCM_RSP_IO_CFG_MMIO
    } ocm_rsp_e;

    typedef struct packed {
        logic valid;
        ocm_kind_e kind;
        ocm_src_e src;
        ocm_rsp_e rsp;
    } ocm_miss_s;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] umask;
        logic [7:0] cmask;
        logic threshold_invert;
    } ocm_evsel_s;

    typedef struct packed {
        logic [2:0] inst_cnt;
        logic [2:0] uops_cnt;
        logic x87_assist_out;
        logic x87_assist_in;
        logic simd_assist;
        logic [47:0] ip;
    } ocm_retire_s;

endpackage

// >>> rtl/ocm_matrix_match.sv
// Request-by-response matrix filter for one second-level miss.
// Assumes the miss descriptor is on core_clk; result is combinational.
`timescale 1ns/10ps
module ocm_matrix_match (
    input wire ocm_pkg::ocm_miss_s miss, // Miss descriptor
    input wire logic [15:0] match_sel, // Matrix select field
    output logic hit // Miss satisfies the matrix
);
    import ocm_pkg::*;

    logic [7:0] req_onehot;
    logic [7:0] rsp_onehot;
    logic pf_l2;

    assign pf_l2 = (miss.src == OCM_SRC_L2_PF);

    always_comb begin
        req_onehot = 8'h00;
        case (miss.kind)
            OCM_KIND_DATA_RD: req_onehot[pf_l2 ? OCM_REQ_PF_DATA_RD : OCM_REQ_DMD_DATA_RD] = 1'b1;
            OCM_KIND_READ_FOR_OWNERSHIP: begin
                req_onehot[pf_l2 ? OCM_REQ_PF_READ_FOR_OWNERSHIP
                    : OCM_REQ_DMD_READ_FOR_OWNERSHIP] = 1'b1;
            end
            OCM_KIND_IFETCH: req_onehot[pf_l2 ? OCM_REQ_PF_IFETCH : OCM_REQ_DMD_IFETCH] = 1'b1;
            OCM_KIND_WRITEBACK: req_onehot[OCM_REQ_WRITEBACK] = 1'b1;
            OCM_KIND_NT_STORE: req_onehot[OCM_REQ_OTHER] = 1'b1;
            default: req_onehot[OCM_REQ_OTHER] = 1'b1;
        endcase
    end

    always_comb begin
        rsp_onehot = 8'h00;
        rsp_onehot[miss.rsp] = 1'b1;
    end

    assign hit = miss.valid
        && |(req_onehot & match_sel[OCM_REQ_LSB +: OCM_GRP_W])
        && |(rsp_onehot & match_sel[OCM_RSP_LSB +: OCM_GRP_W]);

endmodule

// >>> rtl/ocm_counter.sv
// One performance counter with software load, overflow flag and frozen sample IP.
// Assumes increments and the IP come from logic on core_clk.
`timescale 1ns/10ps
module ocm_counter #(
    parameter int CTR_W = 48,
    parameter int IP_W = 48
) (
    input wire logic core_clk, // Core clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [3:0] inc, // Amount to add this cycle
    input wire logic [IP_W-1:0] ip, // Instruction pointer of this cycle
    input wire logic load, // Software write strobe
    input wire logic [CTR_W-1:0] load_val, // Software write value
    input wire logic ovf_clear, // Software clears overflow flag
    output logic [CTR_W-1:0] count, // Counter value
    output logic ovf, // Sticky overflow flag
    output logic ovf_pulse, // One-cycle overflow event
    output logic [IP_W-1:0] sample_ip // IP frozen at overflow
);
    logic [CTR_W:0] sum;

    assign sum = {1'b0, count} + {{(CTR_W - 3){1'b0}}, inc};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (load) begin
            count <= load_val;
        end else begin
            count <= sum[CTR_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovf_pulse <= 1'b0;
        end else begin
            ovf_pulse <= !load && sum[CTR_W];
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovf <= 1'b0;
        end else if (!load && sum[CTR_W]) begin
            ovf <= 1'b1;
        end else if (ovf_clear) begin
            ovf <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sample_ip <= '0;
        end else if (!load && sum[CTR_W]) begin
            sample_ip <= ip;
        end
    end

endmodule

// >>> rtl/ocm_event_unit.sv
// Behaviour
// - Offcore event counts a miss matching any selected request and response bit.
// - Select field is 16 bits: requests low byte, responses high byte.
// - Request bits 0..7: demand read, ownership read, ifetch, writeback, prefetches, other.
// - Response bits 8..15: three L3 hits, scrub, forward, remote, local, I/O.
// - Other request bit covers miscellaneous requests such as non-temporal stores.
// - One shared select register, so one matrix setting per collection period.
// - Demand includes first-level prefetcher; prefetch means second-level prefetcher only.
// - Instructions event with huge count mask and invert counts every cycle.
// - On general counter overflow the sample IP freezes; interrupt waits until unmasked.
// - Micro-op event: count mask 1 counts active cycles, invert idle cycles.
// - Assist events see x87 assists only: any, output, input.
//
// Top of the event qualification block: select register port, offcore matrix
// counter, and a general counter fed by the retirement event qualifier.
// Assumes pipeline inputs and the register port are all on core_clk.
`timescale 1ns/10ps
module ocm_event_unit #(
    parameter int CTR_W = ocm_pkg::OCM_CTR_W,
    parameter int IP_W = ocm_pkg::OCM_IP_W
) (
    input wire logic core_clk, // Core clock, 50 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [11:0] reg_addr, // Register address
    input wire logic [15:0] reg_wdata, // Register write data
    output logic [15:0] reg_rdata, // Register read data, one cycle later
    output logic reg_ack, // Read or write accepted
    output logic reg_err, // Access to an unmapped address
    input wire ocm_pkg::ocm_miss_s miss, // Second-level miss from the pipeline
    input wire ocm_pkg::ocm_retire_s retire, // Retirement activity this cycle
    input wire logic core_halted, // Core is halted this cycle
    input wire logic intr_masked, // Interrupts are masked
    input wire ocm_pkg::ocm_evsel_s gen_sel, // Event select of the general counter
    input wire logic gen_load, // Load the general counter
    input wire logic [CTR_W-1:0] gen_load_val, // Value for general counter load
    input wire logic off_load, // Load the offcore counter
    input wire logic [CTR_W-1:0] off_load_val, // Value for offcore counter load
    input wire logic ovf_clear, // Clear both overflow flags
    output logic [CTR_W-1:0] gen_count, // General counter value
    output logic [CTR_W-1:0] off_count, // Offcore counter value
    output logic gen_ovf, // General counter overflow flag
    output logic off_ovf, // Offcore counter overflow flag
    output logic [IP_W-1:0] sample_ip, // IP frozen at general overflow
    output logic pmi // One-cycle overflow interrupt
);
    import ocm_pkg::*;

    logic [15:0] match_select_r;
    logic match_hit;
    logic [3:0] off_inc;
    logic [3:0] raw_inc;
    logic [3:0] gen_inc;
    logic cmask_true;
    logic gen_ovf_pulse;
    logic off_ovf_pulse;
    logic pmi_pend_r;
    logic pmi_pend_nxt;
    logic [CTR_W-1:0] gen_count_w;
    logic [CTR_W-1:0] off_count_w;
    logic gen_ovf_w;
    logic off_ovf_w;
    logic [IP_W-1:0] sample_ip_w;
    logic addr_hit;

    assign addr_hit = (reg_addr == OCM_MATCH_SELECT_ADDR);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            match_select_r <= OCM_SEL_RESET;
        end else if (reg_wr && addr_hit) begin
            match_select_r <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
        end else begin
            reg_rdata <= (reg_rd && addr_hit) ? match_select_r : 16'h0000;
            reg_ack <= (reg_rd || reg_wr) && addr_hit;
            reg_err <= (reg_rd || reg_wr) && !addr_hit;
        end
    end

    ocm_matrix_match u_match (
        .miss(miss),
        .match_sel(match_select_r),
        .hit(match_hit)
    );

    assign off_inc = {3'b000, match_hit};

    // Raw per-cycle amount of the selected retirement event
    always_comb begin
        raw_inc = 4'h0;
        case (gen_sel.code)
            OCM_EV_INST_DONE: begin
                if (gen_sel.umask == OCM_UM_INST_ANY) begin
                    raw_inc = {1'b0, retire.inst_cnt};
                end
            end
            OCM_EV_UOPS_DONE: begin
                if (gen_sel.umask == OCM_UM_UOPS_ANY) begin
                    raw_inc = {1'b0, retire.uops_cnt};
                end
            end
            OCM_EV_X87_ASSIST: begin
                case (gen_sel.umask)
                    OCM_UM_ASSIST_ANY: raw_inc = {3'b000,
                        retire.x87_assist_out | retire.x87_assist_in};
                    OCM_UM_ASSIST_OUT: raw_inc = {3'b000, retire.x87_assist_out};
                    OCM_UM_ASSIST_IN: raw_inc = {3'b000, retire.x87_assist_in};
                    default: raw_inc = 4'h0;
                endcase
            end
            default: raw_inc = 4'h0;
        endcase
    end

    // huge cmask with invert counts every cycle
    // cmask one counts active cycles
    // The threshold compare uses full width so no cmask wraps into a small value.
    assign cmask_true = ({4'h0, raw_inc} >= gen_sel.cmask) ^ gen_sel.threshold_invert;

    // Halted cycles still count, since the qualifier ignores core_halted by design
    always_comb begin
        if (gen_sel.cmask == 8'h00) begin
            gen_inc = raw_inc;
        end else begin
            gen_inc = {3'b000, cmask_true};
        end
    end

    ocm_counter #(
        .CTR_W(CTR_W),
        .IP_W(IP_W)
    ) u_gen_ctr (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .inc(gen_inc),
        .ip(retire.ip),
        .load(gen_load),
        .load_val(gen_load_val),
        .ovf_clear(ovf_clear),
        .count(gen_count_w),
        .ovf(gen_ovf_w),
        .ovf_pulse(gen_ovf_pulse),
        .sample_ip(sample_ip_w)
    );

    ocm_counter #(
        .CTR_W(CTR_W),
        .IP_W(IP_W)
    ) u_off_ctr (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .inc(off_inc),
        .ip(retire.ip),
        .load(off_load),
        .load_val(off_load_val),
        .ovf_clear(ovf_clear),
        .count(off_count_w),
        .ovf(off_ovf_w),
        .ovf_pulse(off_ovf_pulse),
        .sample_ip()
    );

    // Counter module outputs are already flops; these are the top-level copies
    assign gen_count = gen_count_w;
    assign off_count = off_count_w;
    assign gen_ovf = gen_ovf_w;
    assign off_ovf = off_ovf_w;
    assign sample_ip = sample_ip_w;

    always_comb begin
        pmi_pend_nxt = pmi_pend_r || gen_ovf_pulse || off_ovf_pulse;
        if (!intr_masked) begin
            pmi_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pmi_pend_r <= 1'b0;
            pmi <= 1'b0;
        end else begin
            pmi_pend_r <= pmi_pend_nxt;
            pmi <= !intr_masked && (pmi_pend_r || gen_ovf_pulse || off_ovf_pulse);
        end
    end

endmodule

// >>> testbench/ocm_event_unit_properties.sv
// Port-level assertions for the event qualification block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module ocm_event_unit_properties import ocm_pkg::*; #(
    parameter int CTR_W = 48,
    parameter int IP_W = 48
) (
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [11:0] reg_addr, // Address
    input wire logic [15:0] reg_rdata, // Read data
    input wire logic reg_ack, // Accepted
    input wire logic reg_err, // Unmapped
    input wire ocm_pkg::ocm_miss_s miss, // Miss in
    input wire ocm_pkg::ocm_retire_s retire, // Retire in
    input wire logic intr_masked, // Mask
    input wire ocm_pkg::ocm_evsel_s gen_sel, // Event select
    input wire logic gen_load, // General load
    input wire logic off_load, // Offcore load
    input wire logic [CTR_W-1:0] gen_count, // General count
    input wire logic [CTR_W-1:0] off_count, // Offcore count
    input wire logic gen_ovf, // General overflow
    input wire logic [IP_W-1:0] sample_ip, // Frozen IP
    input wire logic pmi // Interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic acc;
    assign acc = reg_wr | reg_rd;
    a_ack_mapped: assert property (
        acc && reg_addr == OCM_MATCH_SELECT_ADDR |=> reg_ack && !reg_err)
        else $error("mapped access not acknowledged");
    a_err_unmapped: assert property (
        acc && reg_addr != OCM_MATCH_SELECT_ADDR |=> reg_err && !reg_ack && reg_rdata == 16'h0000)
        else $error("unmapped access not refused");
    a_off_single_step: assert property (
        !off_load |=> (off_count - $past(off_count)) <= 1)
        else $error("offcore counter moved by more than one");
    a_all_cycles: assert property (
        gen_sel == {OCM_EV_INST_DONE, OCM_UM_INST_ANY, 8'h10, 1'b1} && !gen_load
        |=> gen_count == $past(gen_count) + 1)
        else $error("cycle count missed a cycle");
    a_uops_cycles: assert property (
        gen_sel.code == OCM_EV_UOPS_DONE && gen_sel.umask == OCM_UM_UOPS_ANY
        && gen_sel.cmask == 8'h01 && !gen_load
        |=> gen_count == $past(gen_count)
            + (($past(retire.uops_cnt) != 3'h0) ^ $past(gen_sel.threshold_invert)))
        else $error("micro-op cycle count wrong");
    a_simd_ignored: assert property (
        gen_sel.code == OCM_EV_X87_ASSIST && !gen_sel.threshold_invert && !gen_load
        && !retire.x87_assist_out && !retire.x87_assist_in |=> $stable(gen_count))
        else $error("assist counted without x87 assist");
    a_ip_frozen: assert property (
        $rose(gen_ovf) |-> sample_ip == $past(retire.ip))
        else $error("sample IP not from overflow cycle");
    a_pmi_held: assert property (
        pmi |-> !$past(intr_masked))
        else $error("interrupt raised while masked");
    a_pmi_prompt: assert property (
        $rose(gen_ovf) && !intr_masked |=> pmi)
        else $error("interrupt late while unmasked");
endmodule

// >>> testbench/ocm_pipe_model.sv
// Behavioural miss and retirement pipeline facing the block.
// Assumes the bench changes go, want and ret_in just after a rising edge.
`timescale 1ns/10ps
module ocm_pipe_model (
    input wire logic core_clk, // Core clock
    input wire logic sys_rst, // Reset
    input wire logic go, // Issue want next cycle
    input wire ocm_pkg::ocm_miss_s want, // Miss to issue
    input wire ocm_pkg::ocm_retire_s ret_in, // Retirement to present
    output ocm_pkg::ocm_miss_s miss, // Miss toward block
    output ocm_pkg::ocm_retire_s retire // Retirement toward block
);
    import ocm_pkg::*;
    // Idle fields flip every cycle so a block that ignores valid is caught
    always_ff @(posedge core_clk) begin
        if (sys_rst) miss <= '0;
        else miss <= go ? {1'b1, want[7:0]} : {1'b0, ~miss[7:0]};
    end
    always_ff @(posedge core_clk) begin
        retire <= ret_in;
    end
endmodule

// >>> testbench/ocm_event_unit_bench.sv
// Self-checking bench for the event qualification block.
// Assumes ocm_pipe_model as the pipeline and the checker bound below.
`timescale 1ns/10ps
module ocm_event_unit_bench;
    import ocm_pkg::*;
    logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, go = 0, saw;
    logic core_halted = 0, intr_masked = 0, gen_load = 0, off_load = 0, ovf_clear = 0;
    logic [11:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0, reg_rdata;
    logic reg_ack, reg_err, gen_ovf, off_ovf, pmi;
    logic [17:0] rsp;
    logic [47:0] gen_load_val = '0, off_load_val = '0, gen_count, off_count, sample_ip, c0;
    ocm_miss_s miss, want = '0;
    ocm_retire_s retire, ret_in = '0;
    ocm_evsel_s gen_sel = '0;
    ocm_src_e sv;
    int failures = 0, num_checks = 0, cyc = 0;
    ocm_kind_e kt[8] = '{OCM_KIND_DATA_RD, OCM_KIND_READ_FOR_OWNERSHIP, OCM_KIND_IFETCH,
        OCM_KIND_WRITEBACK, OCM_KIND_DATA_RD, OCM_KIND_READ_FOR_OWNERSHIP, OCM_KIND_IFETCH,
        OCM_KIND_NT_STORE};
    ocm_event_unit ocm_event_unit_inst (.core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .miss, .retire, .core_halted, .intr_masked,
        .gen_sel, .gen_load, .gen_load_val, .off_load, .off_load_val, .ovf_clear, .gen_count,
        .off_count, .gen_ovf, .off_ovf, .sample_ip, .pmi);
    ocm_pipe_model ocm_pipe_model_inst (.core_clk, .sys_rst, .go, .want, .ret_in, .miss, .retire);
    initial forever #10 core_clk = ~core_clk;
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_acc(input logic wr, input logic [11:0] a, input logic [15:0] d);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        tick;
        reg_wr = 0;
        reg_rd = 0;
        // Answer stands one cycle; the idle edge keeps strobes from toggling in one step
        rsp = {reg_ack, reg_err, reg_rdata};
        tick;
    endtask
    task automatic send(input int n);
        go = 1;
        repeat (n) tick;
        go = 0;
        tick;
    endtask
    task automatic mt(input logic [15:0] sel, input ocm_kind_e k, input ocm_src_e s,
            input ocm_rsp_e r, input logic [47:0] e);
        reg_acc(1, OCM_MATCH_SELECT_ADDR, sel);
        want = '{1'b1, k, s, r};
        c0 = off_count;
        send(1);
        check(off_count, c0 + e);
    endtask
    task automatic gen_run(input ocm_evsel_s s, input logic [2:0] ic, input logic [2:0] uc,
            input logic [2:0] fa, input int n, input logic [47:0] e);
        gen_sel = s;
        tick;
        tick;
        c0 = gen_count;
        ret_in = {ic, uc, fa, 48'h0};
        repeat (n) tick;
        ret_in = '0;
        repeat (3) tick;
        check(gen_count, c0 + e);
    endtask
    task automatic results;
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            results;
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        #1 sys_rst = 0;
        reg_acc(0, OCM_MATCH_SELECT_ADDR, 16'h0000);
        check(rsp[15:0], 16'h0000);
        reg_acc(1, OCM_MATCH_SELECT_ADDR, 16'hA55A);
        check(rsp[17], 1'b1);
        reg_acc(1, 12'h0A6, 16'h1234);
        check(rsp[16], 1'b1);
        reg_acc(0, 12'h1A7, 16'h0000);
        check(rsp[16:0], 17'h10000);
        reg_acc(0, OCM_MATCH_SELECT_ADDR, 16'h0000);
        check(rsp[15:0], 16'hA55A);
        for (int b = 0; b < 8; b++) begin
            sv = (b inside {[4:6]}) ? OCM_SRC_L2_PF : OCM_SRC_CORE;
            mt(16'hFF00 | (16'h1 << b), kt[b], sv, OCM_RSP_LOCAL_MEM, 1);
            mt(16'hFF00 | (~(16'h1 << b) & 16'h00FF), kt[b], sv, OCM_RSP_LOCAL_MEM, 0);
            mt(16'h00FF | (16'h100 << b), kt[1], OCM_SRC_CORE, ocm_rsp_e'(b), 1);
            mt(16'hFFFF ^ (16'h100 << b), kt[1], OCM_SRC_CORE, ocm_rsp_e'(b), 0);
        end
        mt(16'hFF01, OCM_KIND_DATA_RD, OCM_SRC_L1D_PF, OCM_RSP_LOCAL_MEM, 1);
        mt(16'hFF70, OCM_KIND_DATA_RD, OCM_SRC_L1D_PF, OCM_RSP_LOCAL_MEM, 0);
        mt(16'hFF80, OCM_KIND_MISC, OCM_SRC_L2_PF, OCM_RSP_L3_UNSHARED, 1);
        mt(16'h6001, OCM_KIND_DATA_RD, OCM_SRC_CORE, OCM_RSP_REMOTE_MEM, 1);
        mt(16'h6001, OCM_KIND_DATA_RD, OCM_SRC_CORE, OCM_RSP_L3_HIT_MOD_OTHER, 0);
        mt(16'h8070, OCM_KIND_IFETCH, OCM_SRC_L2_PF, OCM_RSP_IO_CFG_MMIO, 1);
        c0 = off_count;
        send(3);
        check(off_count, c0 + 3);
        off_load_val = '1;
        off_load = 1;
        tick;
        off_load = 0;
        send(1);
        check(off_count, 48'h0);
        check(off_ovf, 1'b1);
        gen_run('{OCM_EV_INST_DONE, OCM_UM_INST_ANY, 8'h00, 1'b0}, 3'h4, 0, 0, 2, 8);
        core_halted = 1;
        gen_run('{OCM_EV_INST_DONE, OCM_UM_INST_ANY, 8'h10, 1'b1}, 3'h7, 0, 0, 4, 7);
        gen_run('{OCM_EV_UOPS_DONE, OCM_UM_UOPS_ANY, 8'h01, 1'b0}, 0, 3'h5, 0, 5, 5);
        gen_run('{OCM_EV_UOPS_DONE, OCM_UM_UOPS_ANY, 8'h01, 1'b1}, 0, 3'h5, 0, 5, 3);
        gen_run('{OCM_EV_X87_ASSIST, OCM_UM_ASSIST_ANY, 8'h00, 1'b0}, 0, 0, 3'h4, 3, 3);
        gen_run('{OCM_EV_X87_ASSIST, OCM_UM_ASSIST_OUT, 8'h00, 1'b0}, 0, 0, 3'h4, 3, 3);
        gen_run('{OCM_EV_X87_ASSIST, OCM_UM_ASSIST_IN, 8'h00, 1'b0}, 0, 0, 3'h4, 3, 0);
        gen_run('{OCM_EV_X87_ASSIST, OCM_UM_ASSIST_IN, 8'h00, 1'b0}, 0, 0, 3'h2, 3, 3);
        gen_run('{OCM_EV_X87_ASSIST, OCM_UM_ASSIST_ANY, 8'h00, 1'b0}, 0, 0, 3'h1, 3, 0);
        gen_sel = '{OCM_EV_INST_DONE, OCM_UM_INST_ANY, 8'h10, 1'b1};
        gen_load_val = 48'hFFFF_FFFF_FFFD;
        gen_load = 1;
        intr_masked = 1;
        tick;
        gen_load = 0;
        for (int k = 1; k < 7; k++) begin
            ret_in.ip = 48'(k);
            tick;
        end
        check({gen_ovf, pmi}, 2'b10);
        check(sample_ip, 48'h2);
        intr_masked = 0;
        saw = 0;
        repeat (3) begin
            tick;
            saw |= pmi;
        end
        check(saw, 1'b1);
        ovf_clear = 1;
        tick;
        ovf_clear = 0;
        check({gen_ovf, off_ovf}, 2'b00);
        // Unmasked overflow: interrupt one edge after the wrap
        gen_load_val = '1;
        gen_load = 1;
        tick;
        gen_load = 0;
        repeat (2) tick;
        check({gen_ovf, pmi}, 2'b11);
        results;
    end
endmodule
bind ocm_event_unit ocm_event_unit_properties #(.CTR_W(CTR_W), .IP_W(IP_W)) ocm_chk (.core_clk,
    .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .reg_ack, .reg_err, .miss, .retire,
    .intr_masked, .gen_sel, .gen_load, .off_load, .gen_count, .off_count, .gen_ovf, .sample_ip,
    .pmi);
